//--- design/homing_consts.svh
`ifndef HOMING_CONSTS_SVH
`define HOMING_CONSTS_SVH

// ****************************************
// Register offsets (byte addresses).
// ****************************************
`define HS_OFS_CTRL 8'h00
`define HS_OFS_ZM_VEL 8'h04
`define HS_OFS_RP_VEL 8'h08
`define HS_OFS_MAX_ZM 8'h0C
`define HS_OFS_ZM_TOL 8'h10
`define HS_OFS_RP_OFS 8'h14
`define HS_OFS_REF_COORD 8'h18
`define HS_OFS_INNER 8'h1C
`define HS_OFS_OUTER 8'h20
`define HS_OFS_STATUS 8'h24
`define HS_OFS_CAM_MARK 8'h28
`define HS_OFS_PROBE_CAP 8'h2C

// ****************************************
// Status word bit positions.
// ****************************************
`define HS_ST_SEARCH 0
`define HS_ST_FLY 1
`define HS_ST_WINDOW 3
`define HS_ST_REFSET 11

// ****************************************
// Reset values.
// ****************************************
`define HS_CTRL_RST 8'h00
`define HS_VAL_RST 32'h0000_0000
`define HS_STATUS_RST 16'h0000

`endif

//--- design/homing_pkg.sv
package homing_pkg;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CAM,
        ST_SYNC,
        ST_TORP,
        ST_BRAKE,
        ST_BACK,
        ST_FLY
    } seq_state_t;

    // Configuration bits of the control register, bit 0 last.
    typedef struct packed {
        logic refCoordExt;
        logic probeEdge;
        logic probeSel;
        logic offsetInTravel;
        logic markInv;
        logic extMark;
        logic startDir;
        logic refCam;
    } homing_ctrl_t;

    // Pin inputs that pass the synchroniser together.
    typedef struct packed {
        logic probe2;
        logic probe1;
        logic extMark;
        logic encMark;
        logic typeSel;
        logic start;
        logic cam;
    } pin_set_t;

endpackage

//--- design/axis_homing_sequencer.sv
`timescale 1ns/100ps
`include "homing_consts.svh"

// Operation
// - After cam found, reverse at mark velocity.
// - Search active: cam left, past lower band edge.
// - Record cam end to mark distance.
// - No cam, encoder mark: sync at start.
// - External mark: keep velocity into approach.
// - Override ignored during sync and approach.
// - Rising edge up, falling down, external mark invertible.
// - After mark, approach velocity plus offset.
// - At point load coordinate, set homed.
// - Long stop or reversal: brake, travel back.
// - Type select high runs flying referencing.
// - Start on rising edge, abort on fall.
// - Flying active enables chosen probe edge.
// - Probe capture feeds measurement, valid flag.
// - Flying sets homed, never clears it.
// - Homed, below inner window: position kept.
// - Homed, above outer window: warning, no correction.
// - Between windows: correct actual position.
// - Option adds correction into remaining travel.
// - Default probe 1, rising edge.
// - Search start clears homed bit.
// - Already on cam: go straight to sync.
module axis_homing_sequencer
    import homing_pkg::*;
#(
    parameter int PW = 32
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic refCamInput,
    input wire logic homingStartInput,
    input wire logic homingTypeSelect,
    input wire logic encoderMark,
    input wire logic externalMark,
    input wire logic probe1,
    input wire logic probe2,
    input wire logic signed [PW-1:0] actPos,
    input wire logic signed [PW-1:0] stopDist,
    input wire logic standstill,
    input wire logic signed [PW-1:0] refCoordinateInput,
    output logic [PW-1:0] velCmd,
    output logic moveNeg,
    output logic overrideIgnore,
    output logic posLoad,
    output logic signed [PW-1:0] posLoadValue,
    output logic posCorr,
    output logic signed [PW-1:0] posCorrValue,
    output logic travelCorr,
    output logic probeEvalEnable,
    output logic windowExceededWarning,
    output logic [15:0] homingStatusWord,
    output logic signed [PW-1:0] probeCaptureResult,
    output logic measureValid,
    output logic [PW-1:0] camToMarkDistance
);

    // ****************************************
    // Helpers.
    // ****************************************

    // Magnitude of the difference of two positions.
    function automatic logic [PW-1:0] absDiff(input logic signed [PW-1:0] a,
                                              input logic signed [PW-1:0] b);
        logic signed [PW-1:0] d;
        d = a - b;
        return (d < 0) ? PW'(-d) : PW'(d);
    endfunction

    // Zero extension of a position to the bus width.
    function automatic logic [31:0] toBus(input logic [PW-1:0] v);
        return 32'(v);
    endfunction

    // ****************************************
    // Register file.
    // ****************************************
    homing_ctrl_t ctrl;
    logic [PW-1:0] zeroMarkVelocity;
    logic [PW-1:0] refPointVelocity;
    logic [PW-1:0] maxZeroMarkDistance;
    logic [PW-1:0] zeroMarkTolerance;
    logic signed [PW-1:0] refPointOffset;
    logic signed [PW-1:0] refCoordinateValue;
    logic [PW-1:0] innerWindow;
    logic [PW-1:0] outerWindow;
    logic apbWrite;
    logic apbSetup;

    assign apbSetup = psel & ~penable;
    assign apbWrite = psel & penable & pwrite & pready;

    // APB answer: ready in the first access cycle, no wait states.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `HS_VAL_RST;
        end else begin
            pready <= apbSetup;
            pslverr <= 1'b0;
            if (apbSetup) begin
                prdata <= `HS_VAL_RST;
                unique case (paddr)
                    `HS_OFS_CTRL: prdata <= 32'(ctrl);
                    `HS_OFS_ZM_VEL: prdata <= toBus(zeroMarkVelocity);
                    `HS_OFS_RP_VEL: prdata <= toBus(refPointVelocity);
                    `HS_OFS_MAX_ZM: prdata <= toBus(maxZeroMarkDistance);
                    `HS_OFS_ZM_TOL: prdata <= toBus(zeroMarkTolerance);
                    `HS_OFS_RP_OFS: prdata <= toBus(refPointOffset);
                    `HS_OFS_REF_COORD: prdata <= toBus(refCoordinateValue);
                    `HS_OFS_INNER: prdata <= toBus(innerWindow);
                    `HS_OFS_OUTER: prdata <= toBus(outerWindow);
                    `HS_OFS_STATUS: prdata <= 32'(homingStatusWord);
                    `HS_OFS_CAM_MARK: prdata <= toBus(camToMarkDistance);
                    `HS_OFS_PROBE_CAP: prdata <= toBus(probeCaptureResult);
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Register writes; unmapped or read-only offsets are dropped.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `HS_CTRL_RST;
            zeroMarkVelocity <= PW'(`HS_VAL_RST);
            refPointVelocity <= PW'(`HS_VAL_RST);
            maxZeroMarkDistance <= PW'(`HS_VAL_RST);
            zeroMarkTolerance <= PW'(`HS_VAL_RST);
            refPointOffset <= PW'(`HS_VAL_RST);
            refCoordinateValue <= PW'(`HS_VAL_RST);
            innerWindow <= PW'(`HS_VAL_RST);
            outerWindow <= PW'(`HS_VAL_RST);
        end else if (apbWrite) begin
            unique case (paddr)
                `HS_OFS_CTRL: ctrl <= homing_ctrl_t'(pwdata[7:0]);
                `HS_OFS_ZM_VEL: zeroMarkVelocity <= PW'(pwdata);
                `HS_OFS_RP_VEL: refPointVelocity <= PW'(pwdata);
                `HS_OFS_MAX_ZM: maxZeroMarkDistance <= PW'(pwdata);
                `HS_OFS_ZM_TOL: zeroMarkTolerance <= PW'(pwdata);
                `HS_OFS_RP_OFS: refPointOffset <= PW'(pwdata);
                `HS_OFS_REF_COORD: refCoordinateValue <= PW'(pwdata);
                `HS_OFS_INNER: innerWindow <= PW'(pwdata);
                `HS_OFS_OUTER: outerWindow <= PW'(pwdata);
                default: ;
            endcase
        end
    end

    // ****************************************
    // Pin synchroniser and edge detection.
    // ****************************************
    pin_set_t rawPins;
    pin_set_t syncA;
    pin_set_t syncB;
    pin_set_t syncC;
    pin_set_t pinLvl;
    pin_set_t pinPrev;
    pin_set_t pinRise;
    pin_set_t pinFall;

    assign rawPins = {probe2, probe1, externalMark, encoderMark,
                      homingTypeSelect, homingStartInput, refCamInput};

    // A pin level counts only once the second and third stages agree.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
            pinLvl <= '0;
            pinPrev <= '0;
        end else begin
            syncA <= rawPins;
            syncB <= syncA;
            syncC <= syncB;
            pinLvl <= (syncC & ~(syncB ^ syncC)) | (pinLvl & (syncB ^ syncC));
            pinPrev <= pinLvl;
        end
    end

    assign pinRise = pinLvl & ~pinPrev;
    assign pinFall = ~pinLvl & pinPrev;

    // ****************************************
    // Zero mark selection and qualification.
    // ****************************************
    logic wantRise;
    logic markEdge;
    logic signed [PW-1:0] refCoord;
    logic [PW-1:0] camDist;
    logic [PW-1:0] bandLow;

    // Rising edge when moving up, falling when down; external may invert.
    assign wantRise = ~moveNeg ^ (ctrl.extMark & ctrl.markInv);
    assign markEdge = ctrl.extMark
        ? (wantRise ? pinRise.extMark : pinFall.extMark)
        : (wantRise ? pinRise.encMark : pinFall.encMark);
    assign refCoord = ctrl.refCoordExt ? refCoordinateInput : refCoordinateValue;
    assign bandLow = maxZeroMarkDistance - zeroMarkTolerance;

    // ****************************************
    // Homing sequencer.
    // ****************************************
    seq_state_t state;
    logic camLeft;
    logic signed [PW-1:0] camEndPos;
    logic signed [PW-1:0] target;
    logic signed [PW-1:0] flyDiff;
    logic [PW-1:0] flyAbs;
    logic [PW-1:0] ofsMag;
    logic reached;

    assign flyDiff = refCoord - probeCaptureResult;
    assign flyAbs = absDiff(refCoord, probeCaptureResult);
    assign ofsMag = absDiff(refPointOffset, PW'(0));
    assign camDist = absDiff(actPos, camEndPos);
    assign reached = moveNeg ? (actPos <= target) : (actPos >= target);

    // Motion sequence, status bits and flying corrections.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            velCmd <= '0;
            moveNeg <= 1'b0;
            overrideIgnore <= 1'b0;
            camLeft <= 1'b0;
            camEndPos <= '0;
            target <= '0;
            posLoad <= 1'b0;
            posLoadValue <= '0;
            posCorr <= 1'b0;
            posCorrValue <= '0;
            travelCorr <= 1'b0;
            windowExceededWarning <= 1'b0;
            homingStatusWord <= `HS_STATUS_RST;
            camToMarkDistance <= '0;
        end else begin
            posLoad <= 1'b0;
            posCorr <= 1'b0;
            travelCorr <= 1'b0;
            if (state != ST_IDLE && !pinLvl.start) begin
                // Start input dropped: abort and stop.
                state <= ST_IDLE;
                velCmd <= '0;
                overrideIgnore <= 1'b0;
                homingStatusWord[`HS_ST_SEARCH] <= 1'b0;
                homingStatusWord[`HS_ST_FLY] <= 1'b0;
            end else begin
                unique case (state)
                    ST_IDLE: begin
                        if (pinRise.start && pinLvl.typeSel) begin
                            state <= ST_FLY;
                            homingStatusWord[`HS_ST_FLY] <= 1'b1;
                            homingStatusWord[`HS_ST_WINDOW] <= 1'b0;
                            windowExceededWarning <= 1'b0;
                        end else if (pinRise.start) begin
                            homingStatusWord[`HS_ST_REFSET] <= 1'b0;
                            camLeft <= 1'b0;
                            velCmd <= zeroMarkVelocity;
                            if (ctrl.refCam && pinLvl.cam) begin
                                state <= ST_SYNC;
                                moveNeg <= ~ctrl.startDir;
                                overrideIgnore <= 1'b1;
                            end else if (ctrl.refCam) begin
                                state <= ST_CAM;
                                moveNeg <= ctrl.startDir;
                                overrideIgnore <= 1'b0;
                            end else begin
                                state <= ST_SYNC;
                                moveNeg <= ctrl.startDir;
                                overrideIgnore <= 1'b1;
                            end
                        end
                    end
                    ST_CAM: begin
                        // Cam found: turn back at zero mark velocity.
                        if (pinLvl.cam) begin
                            state <= ST_SYNC;
                            moveNeg <= ~ctrl.startDir;
                            velCmd <= zeroMarkVelocity;
                            overrideIgnore <= 1'b1;
                        end
                    end
                    ST_SYNC: begin
                        if (ctrl.refCam && !pinLvl.cam && !camLeft) begin
                            camLeft <= 1'b1;
                            camEndPos <= actPos;
                        end
                        if (ctrl.refCam && camLeft && camDist >= bandLow) begin
                            homingStatusWord[`HS_ST_SEARCH] <= 1'b1;
                        end
                        if (markEdge && (!ctrl.refCam || homingStatusWord[`HS_ST_SEARCH])) begin
                            if (ctrl.refCam) begin
                                camToMarkDistance <= camDist;
                            end
                            target <= moveNeg ? actPos - refPointOffset
                                              : actPos + refPointOffset;
                            if (stopDist > $signed(ofsMag) || refPointOffset < 0) begin
                                state <= ST_BRAKE;
                                velCmd <= '0;
                            end else begin
                                state <= ST_TORP;
                                velCmd <= ctrl.extMark ? zeroMarkVelocity
                                                       : refPointVelocity;
                            end
                        end
                    end
                    ST_BRAKE: begin
                        // Standstill reached: head back towards the point.
                        if (standstill) begin
                            state <= ST_BACK;
                            moveNeg <= (target < actPos);
                            velCmd <= refPointVelocity;
                        end
                    end
                    ST_TORP, ST_BACK: begin
                        if (reached) begin
                            state <= ST_IDLE;
                            velCmd <= '0;
                            overrideIgnore <= 1'b0;
                            posLoad <= 1'b1;
                            posLoadValue <= refCoord;
                            homingStatusWord[`HS_ST_REFSET] <= 1'b1;
                            homingStatusWord[`HS_ST_SEARCH] <= 1'b0;
                        end
                    end
                    ST_FLY: begin
                        // A valid capture is judged against the windows once homed; before that it corrects at once.
                        if (measureValid) begin
                            if (!homingStatusWord[`HS_ST_REFSET]) begin
                                homingStatusWord[`HS_ST_REFSET] <= 1'b1;
                                posCorr <= 1'b1;
                                posCorrValue <= flyDiff;
                                travelCorr <= ctrl.offsetInTravel;
                            end else if (flyAbs > outerWindow) begin
                                homingStatusWord[`HS_ST_WINDOW] <= 1'b1;
                                windowExceededWarning <= 1'b1;
                            end else if (flyAbs >= innerWindow) begin
                                posCorr <= 1'b1;
                                posCorrValue <= flyDiff;
                                travelCorr <= ctrl.offsetInTravel;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Probe evaluation.
    // ****************************************
    logic probeEdge;

    // Chosen probe and edge; factory setting is probe 1, rising.
    assign probeEdge = ctrl.probeSel
        ? (ctrl.probeEdge ? pinFall.probe2 : pinRise.probe2)
        : (ctrl.probeEdge ? pinFall.probe1 : pinRise.probe1);

    // Captures the position on a probe edge while flying is active.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            probeEvalEnable <= 1'b0;
            probeCaptureResult <= '0;
            measureValid <= 1'b0;
        end else begin
            probeEvalEnable <= homingStatusWord[`HS_ST_FLY];
            measureValid <= 1'b0;
            if (probeEvalEnable && probeEdge) begin
                probeCaptureResult <= actPos;
                measureValid <= 1'b1;
            end
        end
    end

endmodule // axis_homing_sequencer

//--- bench/homing_properties.sv
`timescale 1ns/100ps
// ****************************************
// Port checker for the homing sequencer.
// ****************************************
module homing_properties #(
    parameter int PW = 32
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic homingStartInput,
    input wire logic [PW-1:0] velCmd,
    input wire logic overrideIgnore,
    input wire logic posLoad,
    input wire logic posCorr,
    input wire logic probeEvalEnable,
    input wire logic windowExceededWarning,
    input wire logic [15:0] homingStatusWord,
    input wire logic measureValid
);
    // All checks run on the one clock and rest during reset.
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_load_sets_home: assert property (posLoad |-> ##[0:1] homingStatusWord[11])
        else $error("reference bit not set after load");
    a_load_one_cycle: assert property (posLoad |=> !posLoad)
        else $error("load pulse too long");
    a_corr_after_valid: assert property (posCorr |-> $past(measureValid))
        else $error("correction without valid capture");
    a_probe_follows_fly: assert property (##1 probeEvalEnable == $past(homingStatusWord[1]))
        else $error("probe enable does not follow flying bit");
    a_warn_no_corr: assert property ($rose(windowExceededWarning) |-> !posCorr && homingStatusWord[3])
        else $error("window warning with correction or no status");
    a_abort_to_idle: assert property ($fell(homingStartInput) |-> ##[1:10] (homingStatusWord[1:0] == 2'b00 && velCmd == '0))
        else $error("abort did not return to idle");
    a_search_clears_home: assert property ($rose(overrideIgnore) |-> ##[0:1] !homingStatusWord[11])
        else $error("search start kept reference bit");
    a_valid_one_cycle: assert property (measureValid |=> !measureValid)
        else $error("valid pulse too long");
    c_load: cover property (posLoad);
    c_corr: cover property (posCorr);
    c_warn: cover property ($rose(windowExceededWarning));
endmodule // homing_properties

bind axis_homing_sequencer homing_properties #(.PW(PW)) chk (.sys_clk, .rst_n, .homingStartInput,
    .velCmd, .overrideIgnore, .posLoad, .posCorr, .probeEvalEnable, .windowExceededWarning,
    .homingStatusWord, .measureValid);

//--- bench/axis_partner.sv
`timescale 1ns/100ps
// ****************************************
// Axis and encoder model on the far side.
// ****************************************
module axis_partner #(
    parameter int MARK = 100
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [31:0] velCmd,
    input wire logic moveNeg,
    input wire logic posLoad,
    input wire logic signed [31:0] posLoadValue,
    input wire logic posCorr,
    input wire logic signed [31:0] posCorrValue,
    output logic signed [31:0] actPos,
    output logic standstill,
    output logic encoderMark
);
    // Position follows the speed command unless loaded or corrected.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            actPos <= 32'sh0000_0000;
        end else if (posLoad) begin
            actPos <= posLoadValue;
        end else if (posCorr) begin
            actPos <= actPos + posCorrValue;
        end else if (moveNeg) begin
            actPos <= actPos - signed'(velCmd);
        end else begin
            actPos <= actPos + signed'(velCmd);
        end
    end
    // The mark is high over a band of 40 units on either side of zero.
    assign encoderMark = (actPos >= MARK && actPos < MARK + 40) ||
        (actPos <= -MARK && actPos > -MARK - 40);
    assign standstill = (velCmd == 32'h0000_0000);
endmodule // axis_partner

//--- bench/tb.sv
`timescale 1ns/100ps
`include "homing_consts.svh"
// ****************************************
// Self-checking bench for the homing sequencer.
// ****************************************
module tb;
    logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic homingStartInput = 1'b0, homingTypeSelect = 1'b0, probe1 = 1'b0, probe2 = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, velCmd, rdv, seed = 32'h0000_3b04;
    logic pready, pslverr, moveNeg, overrideIgnore, posLoad, posCorr, errv, standstill;
    logic probeEvalEnable, windowExceededWarning, measureValid, encoderMark, travelCorr;
    logic signed [31:0] actPos, posLoadValue, posCorrValue, probeCaptureResult, flyBase;
    logic [15:0] homingStatusWord;
    logic [31:0] expQ[$];
    logic travelExp = 1'b0;
    int mismatches = 0;
    int testsRun = 0;

    axis_homing_sequencer dut (
        .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .refCamInput(1'b0), .homingStartInput, .homingTypeSelect, .encoderMark,
        .externalMark(encoderMark), .probe1, .probe2, .actPos, .stopDist(32'sh0000_0000),
        .standstill, .refCoordinateInput(32'sh0000_0007), .velCmd, .moveNeg,
        .overrideIgnore, .posLoad, .posLoadValue, .posCorr, .posCorrValue, .travelCorr,
        .probeEvalEnable, .windowExceededWarning, .homingStatusWord,
        .probeCaptureResult, .measureValid, .camToMarkDistance()
    );
    axis_partner axis (
        .sys_clk, .rst_n, .velCmd, .moveNeg, .posLoad, .posLoadValue, .posCorr,
        .posCorrValue, .actPos, .standstill, .encoderMark
    );

    // Pseudo-random source with a fixed start.
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Closing report and end of run.
    task automatic tally_and_finish();
        if (mismatches == 0 && testsRun > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Word comparison.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // A wait that ran out ends the run.
    task automatic lost();
        mismatches++;
        $display("wrong value at %0t: wait ran out", $time);
        tally_and_finish();
    endtask
    // One APB transfer, held until pready is seen at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) lost();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdv, exp);
    endtask
    // Waits until every noted result has been seen.
    task automatic drain();
        int i;
        for (i = 0; i < 3000 && expQ.size() > 0; i++) @(posedge sys_clk);
        if (expQ.size() > 0) lost();
    endtask

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Each load or correction pulse is matched against the oldest note.
    always @(posedge sys_clk) begin
        if (posLoad === 1'b1 || posCorr === 1'b1) begin
            if (expQ.size() == 0) chk(32'h0000_0001, 32'h0000_0000);
            else chk(posLoad ? posLoadValue : posCorrValue, expQ.pop_front());
        end
        if (posCorr === 1'b1) chk(32'(travelCorr), 32'(travelExp));
    end

    initial begin
        int i, d, dir;
        logic homed;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(`HS_OFS_CTRL, 32'h0000_0000);
        rd(`HS_OFS_STATUS, 32'h0000_0000);
        apb(1'b1, `HS_OFS_STATUS, 32'h0000_ffff);
        rd(`HS_OFS_STATUS, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        chk(32'(errv), 32'h0000_0001);
        apb(1'b1, `HS_OFS_ZM_VEL, 32'h0000_0004);
        rd(`HS_OFS_ZM_VEL, 32'h0000_0004);
        apb(1'b1, `HS_OFS_RP_VEL, 32'h0000_0002);
        apb(1'b1, `HS_OFS_INNER, 32'h0000_000a);
        apb(1'b1, `HS_OFS_OUTER, 32'h0000_0032);
        // Searches without cam, both start directions, ending on coordinate zero, then on pin coordinate 7.
        for (dir = 0; dir < 2; dir++) begin
            // Second pass: external inverted mark, negative offset, pin coordinate.
            apb(1'b1, `HS_OFS_CTRL, dir ? 32'h0000_008e : 32'h0000_0000);
            apb(1'b1, `HS_OFS_RP_OFS, dir ? 32'hffff_ffd8 : 32'h0000_0028);
            expQ.push_back(dir ? 32'h0000_0007 : 32'h0000_0000);
            homingStartInput <= 1'b1;
            repeat (12) @(posedge sys_clk);
            chk(32'(moveNeg), 32'(dir));
            chk(32'(overrideIgnore), 32'h0000_0001);
            drain();
            chk(32'(moveNeg), 32'h0000_0000);
            repeat (2) @(posedge sys_clk);
            chk(32'(homingStatusWord), 32'h0000_0800);
            homingStartInput <= 1'b0;
            repeat (12) @(posedge sys_clk);
        end
        // A search dropped in mid-run.
        apb(1'b1, `HS_OFS_CTRL, 32'h0000_0000);
        homingStartInput <= 1'b1;
        repeat (12) @(posedge sys_clk);
        chk(32'(homingStatusWord[11]), 32'h0000_0000);
        chk(velCmd, 32'h0000_0004);
        homingStartInput <= 1'b0;
        repeat (12) @(posedge sys_clk);
        chk(32'(homingStatusWord), 32'h0000_0000);
        chk(velCmd, 32'h0000_0000);
        // Flying runs: unhomed, inside, between, outside, then probe 2 falling.
        homed = 1'b0;
        homingTypeSelect <= 1'b1;
        for (i = 0; i < 5; i++) begin
            d = (i < 2) ? 3 : (i == 3) ? 200 : 11 + int'(xorshift() % 39);
            if (i == 4) d = -d;
            travelExp = (i == 2);
            flyBase = actPos;
            apb(1'b1, `HS_OFS_CTRL, (i == 4) ? 32'h0000_0060 : 32'(travelExp) << 4);
            apb(1'b1, `HS_OFS_REF_COORD, flyBase + d);
            if ((!homed || d >= 10 || d <= -10) && d <= 50 && d >= -50) expQ.push_back(32'(d));
            homingStartInput <= 1'b1;
            repeat (10) @(posedge sys_clk);
            chk(32'(probeEvalEnable), 32'h0000_0001);
            probe1 <= (i != 4);
            probe2 <= (i == 4);
            repeat (10) @(posedge sys_clk);
            probe1 <= 1'b0;
            probe2 <= 1'b0;
            repeat (12) @(posedge sys_clk);
            drain();
            chk(probeCaptureResult, flyBase);
            chk(32'(windowExceededWarning), 32'(i == 3));
            chk(32'(homingStatusWord[3]), 32'(i == 3));
            chk(32'(homingStatusWord[11]), 32'h0000_0001);
            homed = 1'b1;
            homingStartInput <= 1'b0;
            repeat (12) @(posedge sys_clk);
        end
        tally_and_finish();
    end
endmodule // tb
